/* tb/pin_partner.sv */
// Purpose: Far-side pin model with capture sources and an external count clock.
// Assumes: A pin that the timer drives reads back its own level.
// Notes: The count clock stands still at 0 while ext_run is low.
`timescale 1ns/1ps
module pin_partner
   import timer_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic ext_run,
   input wire logic [5:0] src,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   output logic [5:0] pin_in
);
   logic [3:0] half_reg;
   logic ext_clk_reg;
   logic [5:0] drive;
   // A half period of 16 bus cycles keeps the clock under 4 MHz and under half the bus rate.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst || !ext_run) begin
         half_reg <= 4'h0;
         ext_clk_reg <= 1'b0;
      end else begin
         half_reg <= half_reg + 4'h1;
         if (half_reg == 4'hF) begin
            ext_clk_reg <= ~ext_clk_reg;
         end
      end
   end
   assign drive = {src[5:1], ext_run ? ext_clk_reg : src[0]};
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule

/* tb/tb_timer_pwm_overflow_control.sv */
// Purpose: Self-checking bench for the six-channel timer.
// Assumes: Register reads return data one cycle after the strobe.
// Notes: Duty is counted over 100 cycles, ten whole periods of 10 counts.
`timescale 1ns/1ps
`include "timer_regs.svh"
module tb_timer_pwm_overflow_control
   import timer_pkg::*;
;
   logic clock, nrst, wr, rd, wait_mode, stop_mode, debug_break, halt_flag_clear_enable, ext_run;
   logic [5:0] addr, src, pin_in, pin_out, pin_oe, chan_irq;
   logic [7:0] wdata, rdata, v;
   logic wrap_irq, wake_request;
   int n_mismatch, samples_checked;
   timer_module uut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .wait_mode(wait_mode), .stop_mode(stop_mode), .debug_break(debug_break),
      .halt_flag_clear_enable(halt_flag_clear_enable), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .wrap_irq(wrap_irq), .chan_irq(chan_irq), .wake_request(wake_request));
   pin_partner partner (.clock(clock), .nrst(nrst), .ext_run(ext_run), .src(src), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_in(pin_in));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic duty(input int exp);
      int ones;
      ones = 0;
      repeat (30) @(posedge clock);
      repeat (100) begin
         @(posedge clock);
         #1 ones += (pin_out[0] === 1'b1);
      end
      check(16'(ones), 16'(exp));
   endtask
   task automatic pulse();
      @(posedge clock);
      src[2] <= 1'b1;
      repeat (8) @(posedge clock);
      src[2] <= 1'b0;
      repeat (8) @(posedge clock);
   endtask
   task automatic t_reset();
      rd_reg(`ADDR_CTRL, v);
      check(16'(v), 16'h0020);
      rd_reg(`ADDR_PER_HI, v);
      check(16'(v), 16'h00FF);
      rd_reg(6'h3F, v);
      check(16'(v), 16'h0000);
      repeat (20) @(posedge clock);
      rd_reg(`ADDR_CNT_LO, v);
      check(16'(v), 16'h0000);
   endtask
   task automatic t_divider();
      logic [7:0] a, b, d;
      wr_reg(`ADDR_CH_BASE, 8'h1A);
      for (int n = 0; n < 8; n++) begin
         ext_run <= (n == 7);
         wr_reg(`ADDR_CTRL, 8'h10 | 8'(n));
         rd_reg(`ADDR_CNT_LO, a);
         repeat ((n == 7) ? 254 : 126) @(posedge clock);
         rd_reg(`ADDR_CNT_LO, b);
         d = b - a;
         check(16'(d), (n == 7) ? 16'h0008 : 16'(128 >> n));
      end
      check(16'(pin_oe[0]), 16'h0000);
      wr_reg(`ADDR_CTRL, 8'h30);
      ext_run <= 1'b0;
      rd_reg(`ADDR_CTRL, v);
      check(16'(v), 16'h0020);
   endtask
   task automatic t_pwm();
      logic [7:0] cfg[4] = '{8'h1A, 8'h1E, 8'h18, 8'h1B};
      int exp_ones[4] = '{40, 60, 0, 100};
      wr_reg(`ADDR_PER_HI, 8'h00);
      wr_reg(`ADDR_PER_LO, 8'h09);
      wr_reg(`ADDR_CH_BASE + 6'h02, 8'h03);
      wr_reg(`ADDR_CTRL, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr_reg(`ADDR_CH_BASE, cfg[i]);
         duty(exp_ones[i]);
      end
      check(16'(pin_oe[0]), 16'h0001);
      wr_reg(`ADDR_CH_BASE, 8'h2A);
      duty(40);
      wr_reg(`ADDR_CH_BASE + 6'h05, 8'h06);
      duty(70);
      rd_reg(`ADDR_CH_BASE + 6'h03, v);
      check(16'(v), 16'h0000);
      check(16'(pin_oe[1]), 16'h0000);
      rd_reg(`ADDR_CTRL, v);
      check(16'(v[7]), 16'h0001);
   endtask
   task automatic t_wrap();
      logic [7:0] a, b;
      wr_reg(`ADDR_CTRL, 8'h40);
      repeat (30) @(posedge clock);
      #1 check(16'(wrap_irq), 16'h0001);
      wait_mode <= 1'b1;
      wr_reg(`ADDR_PER_LO, 8'h55);
      rd_reg(`ADDR_CTRL, v);
      check(16'(v), 16'h0000);
      check(16'(wake_request), 16'h0001);
      wait_mode <= 1'b0;
      rd_reg(`ADDR_PER_LO, v);
      check(16'(v), 16'h0009);
      for (int m = 0; m < 2; m++) begin
         stop_mode <= (m == 0);
         debug_break <= (m == 1);
         rd_reg(`ADDR_CNT_LO, a);
         repeat (20) @(posedge clock);
         rd_reg(`ADDR_CNT_LO, b);
         check(16'(b), 16'(a));
      end
      rd_reg(`ADDR_CTRL, v);
      wr_reg(`ADDR_CTRL, 8'h40);
      rd_reg(`ADDR_CTRL, v);
      check(16'(v[7]), 16'h0001);
      debug_break <= 1'b0;
      wr_reg(`ADDR_CTRL, 8'h60);
      rd_reg(`ADDR_CTRL, v);
      check(16'(v), 16'h00E0);
      wr_reg(`ADDR_CTRL, 8'h60);
      rd_reg(`ADDR_CTRL, v);
      check(16'(v), 16'h0060);
      check(16'(wrap_irq), 16'h0000);
      wr_reg(`ADDR_CTRL, 8'hE0);
      rd_reg(`ADDR_CTRL, v);
      check(16'(v), 16'h0060);
   endtask
   task automatic t_capture();
      wr_reg(`ADDR_CH_BASE + 6'h06, 8'h44);
      pulse();
      check(16'(chan_irq[2]), 16'h0000);
      wr_reg(`ADDR_CTRL, 8'h00);
      debug_break <= 1'b1;
      pulse();
      check(16'(chan_irq[2]), 16'h0000);
      debug_break <= 1'b0;
      pulse();
      check(16'(chan_irq[2]), 16'h0001);
      check(16'(pin_oe[2]), 16'h0000);
   endtask
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      finish_test();
   end
   initial begin
      {nrst, wr, rd, wait_mode, stop_mode, debug_break, halt_flag_clear_enable, ext_run} = 8'h00;
      addr = 6'h00;
      wdata = 8'h00;
      src = 6'h00;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      t_reset();
      t_divider();
      t_pwm();
      t_wrap();
      t_capture();
      finish_test();
   end
endmodule

/* verilog/channel_unit.sv */
// Purpose: One timer channel: compare output, PWM levels, input capture and pair buffering.
// Assumes: tick, ovf and cnt_next come from the counter on the same clock.
// Notes: Odd channels take disabled high while the even partner links them.
`timescale 1ns/1ps
`include "timer_regs.svh"
module channel_unit
   import timer_pkg::*;
#(
   parameter bit CAN_LINK = 1'b0
)
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic tick,
   input wire logic ovf,
   input wire count_t cnt_next,
   input wire count_t val_own,
   input wire count_t val_partner,
   input wire logic wr_own,
   input wire logic wr_partner,
   input wire logic [7:0] ctrl,
   input wire logic disabled,
   input wire logic force_input,
   input wire logic cap_ok,
   input wire logic pin_sync,
   output logic event_pulse,
   output logic cap_pulse,
   output logic pin_out,
   output logic pin_oe
);
   logic out_reg;
   logic prev_reg;
   logic last_reg;
   logic act_reg;
   chan_mode_e mode;
   wire [1:0] els = ctrl[`CH_ELS_HI:`CH_ELS_LO];
   wire linked = CAN_LINK & ctrl[`CH_LINK];
   wire tov = ctrl[`CH_TOV];
   wire full = ctrl[`CH_MAX];
   // Link beats the unlinked mode bit.
   assign mode = (disabled || els == `ELS_OFF) ? mode_idle :
                 (linked || ctrl[`CH_UNLINKED]) ? mode_compare : mode_capture;
   wire count_t cmp_val = (linked && act_reg) ? val_partner : val_own;
   wire cmp = tick & (cnt_next == cmp_val);
   wire pulse_lvl = ~els[0];
   wire rise = pin_sync & ~prev_reg;
   wire fall = ~pin_sync & prev_reg;
   wire edge_hit = (els == `ELS_TOGGLE) ? rise : (els == `ELS_CLEAR) ? fall : (rise | fall);
   assign cap_pulse = (mode == mode_capture) & cap_ok & edge_hit;
   assign event_pulse = ((mode == mode_compare) & cmp) | cap_pulse;
   assign pin_out = out_reg;
   assign pin_oe = (mode == mode_compare) & ~force_input;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         out_reg <= 1'b0;
         prev_reg <= 1'b0;
         last_reg <= 1'b0;
         act_reg <= 1'b0;
      end else begin
         prev_reg <= pin_sync;
         if (!linked) begin
            last_reg <= 1'b0;
            act_reg <= 1'b0;
         end else begin
            if (wr_partner) begin
               last_reg <= 1'b1;
            end else if (wr_own) begin
               last_reg <= 1'b0;
            end
            if (ovf) begin
               act_reg <= last_reg;
            end
         end
         if (mode == mode_idle) begin
            out_reg <= ctrl[`CH_UNLINKED];
         end else if (mode == mode_compare) begin
            if (tov && full) begin
               out_reg <= pulse_lvl;
            end else if (ovf && tov) begin
               out_reg <= pulse_lvl;
            end else if (cmp) begin
               case (els)
                  `ELS_TOGGLE: out_reg <= ~out_reg;
                  `ELS_CLEAR: out_reg <= 1'b0;
                  `ELS_SET: out_reg <= 1'b1;
                  default: out_reg <= out_reg;
               endcase
            end
         end
      end
   end
   AST_FULL_DUTY: assert property (@(posedge clock) disable iff (!nrst)
      (mode == mode_compare && tov && full && els == `ELS_CLEAR) [*2] |-> pin_out)
      else $error("full duty output left pulse level");
   AST_NO_OVF_TOGGLE: assert property (@(posedge clock) disable iff (!nrst)
      (mode == mode_compare && !tov && $past(mode) == mode_compare && els == `ELS_CLEAR && !pin_out)
      |=> !pin_out || $past(!(mode == mode_compare && els == `ELS_CLEAR)))
      else $error("zero duty output went high");
   AST_LINK_PRIO: assert property (@(posedge clock) disable iff (!nrst)
      (linked && !disabled && els != `ELS_OFF) |-> mode == mode_compare)
      else $error("linked channel not in compare mode");
   COV_BUF_SWAP: cover property (@(posedge clock) disable iff (!nrst) linked && ovf && act_reg != last_reg);
   COV_CAPTURE: cover property (@(posedge clock) disable iff (!nrst) cap_pulse);
endmodule

/* verilog/prescaler.sv */
// Purpose: Counter clock source: divided bus clock or external pin clock.
// Assumes: ext_sync is already synchronised to clock.
// Notes: tick is a one-cycle enable for the counter.
`timescale 1ns/1ps
`include "timer_regs.svh"
module prescaler
   import timer_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic run,
   input wire logic clear,
   input wire div_sel_t sel,
   input wire logic ext_sync,
   output logic tick
);
   logic [5:0] div_reg;
   logic ext_prev_reg;
   wire [5:0] mask = 6'((7'h01 << sel) - 7'h01);
   wire ext_edge = ext_sync & ~ext_prev_reg;
   assign tick = run & ((sel == `DIV_EXT) ? ext_edge : ((div_reg & mask) == mask));
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         div_reg <= 6'h00;
         ext_prev_reg <= 1'b0;
      end else begin
         ext_prev_reg <= ext_sync;
         if (clear) begin
            div_reg <= 6'h00;
         end else if (run) begin
            div_reg <= div_reg + 6'h01;
         end
      end
   end
endmodule

/* verilog/timer_module.sv */
// Purpose: Six-channel timer with counter, period limit, PWM channels and status/control register.
// Assumes: Register port on the bus clock; pins arrive asynchronously.
// Notes: Counter readout latching and per-byte staging are handled elsewhere.
// Function
// - Compare drives complement of the pulse level.
// - Even channel links with next odd channel.
// - Link bit overrides unlinked mode bit.
// - No overflow toggle gives zero duty output.
// - Full duty plus toggle holds 100% output.
// - Wrap sets flag; enabled flag requests interrupt.
// - Channel events set flag; enabled flag interrupts.
// - Wait keeps counting, blocks access, wakes on interrupt.
// - Stop freezes counter and captures, keeps state.
// - Debug break freezes counter, blocks captures.
// - Break protects flags unless clear enable set.
// - Divider code 111 takes channel 0 pin clock.
// - Wrap flag clears by read-then-write-zero only.
// - Halt bit freezes counter; resets set, irq enable clear.
// - Halt suppresses input captures.
// - Six independent channels; even ones may buffer.
// - Clear bit zeros counter and prescaler, reads zero.
// - Divider codes give bus clock over powers two.
// - Restart after modulo; upper period write blocks wrap.
// - Last written set controls from next overflow.
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_module
   import timer_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [5:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic wait_mode,
   input wire logic stop_mode,
   input wire logic debug_break,
   input wire logic halt_flag_clear_enable,
   input wire logic [5:0] pin_in,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe,
   output logic wrap_irq,
   output logic [5:0] chan_irq,
   output logic wake_request
);
   function automatic logic [5:0] ch_addr(input int ch, input logic [5:0] ofs);
      ch_addr = 6'(`ADDR_CH_BASE + `CH_STRIDE * ch + ofs);
   endfunction

   // Returns {flag, armed} after one cycle of the read-then-write-zero clearing sequence.
   function automatic logic [1:0] flag_upd(input logic flag, input logic armed, input logic set,
                                           input logic rd_hit, input logic wr_hit, input logic wbit,
                                           input logic may);
      logic f;
      logic a;
      f = flag;
      a = armed;
      if (may && wr_hit) begin
         if (armed && !wbit) begin
            f = 1'b0;
         end
         a = 1'b0;
      end
      if (may && rd_hit && flag) begin
         a = 1'b1;
      end
      if (set) begin
         f = 1'b1;
         a = 1'b0;
      end
      flag_upd = {f, a};
   endfunction

   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic [7:0] rdata_reg;
   logic wrap_ie_reg;
   logic halt_reg;
   div_sel_t div_reg;
   count_t cnt_reg;
   count_t per_reg;
   logic inhibit_reg;
   logic [7:0] chc_reg [6];
   count_t val_reg [6];
   logic [6:0] flag_reg;
   logic [6:0] arm_reg;
   logic [6:0] flag_next;
   logic [6:0] arm_next;
   logic [5:0] ch_evt;
   logic [5:0] cap_evt;
   logic [5:0] wr_val;
   logic [7:0] ch_rd [6];
   logic tick;

   wire access = ~wait_mode;
   wire wr_ok = wr & access;
   wire rd_ok = rd & access;
   wire may_clear = ~debug_break | halt_flag_clear_enable;
   wire wr_ctrl = wr_ok & (addr == `ADDR_CTRL);
   wire clr_pulse = wr_ctrl & wdata[`CTRL_CLEAR];
   wire run = ~halt_reg & ~stop_mode & ~debug_break;
   wire cap_ok = ~halt_reg & ~stop_mode & ~debug_break;
   // The counter returns to zero on the tick after it has equalled the period.
   wire count_t cnt_next = (cnt_reg == per_reg) ? `CNT_RESET : cnt_reg + 16'h0001;
   wire ovf = tick & ~clr_pulse & (cnt_next == per_reg);
   wire wrap_set = ovf & ~inhibit_reg;
   wire ext_sel = (div_reg == `DIV_EXT);

   // The pin clock reaches the prescaler only through the two-flop synchroniser.
   prescaler u_prescaler (
      .clock(clock),
      .nrst(nrst),
      .run(run),
      .clear(clr_pulse),
      .sel(div_reg),
      .ext_sync(sync2_reg[0]),
      .tick(tick)
   );

   // Odd channels fall silent while their even partner holds the link bit.
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : gen_ch
         localparam int P = g ^ 1;
         wire linked_by_even = (g % 2 == 1) ? chc_reg[P][`CH_LINK] : 1'b0;
         assign wr_val[g] = wr_ok & ((addr == ch_addr(g, `CH_OFS_HI)) | (addr == ch_addr(g, `CH_OFS_LO)));
         assign ch_rd[g] = linked_by_even ? 8'h00 : chc_reg[g] & {~arm_reg[g] | 1'b1, 7'h7F};
         channel_unit #(.CAN_LINK(g % 2 == 0)) u_ch (
            .clock(clock),
            .nrst(nrst),
            .tick(tick & ~clr_pulse),
            .ovf(ovf),
            .cnt_next(cnt_next),
            .val_own(val_reg[g]),
            .val_partner(val_reg[P]),
            .wr_own(wr_val[g]),
            .wr_partner(wr_val[P]),
            .ctrl(chc_reg[g]),
            .disabled(linked_by_even),
            .force_input(g == 0 ? ext_sel : 1'b0),
            .cap_ok(cap_ok),
            .pin_sync(sync2_reg[g]),
            .event_pulse(ch_evt[g]),
            .cap_pulse(cap_evt[g]),
            .pin_out(pin_out[g]),
            .pin_oe(pin_oe[g])
         );
         assign {flag_next[g], arm_next[g]} = flag_upd(flag_reg[g], arm_reg[g], ch_evt[g],
            rd_ok & (addr == ch_addr(g, `CH_OFS_CTRL)), wr_ok & (addr == ch_addr(g, `CH_OFS_CTRL)),
            wdata[`CH_FLAG], may_clear);
         assign chan_irq[g] = flag_reg[g] & chc_reg[g][`CH_IE];
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               chc_reg[g] <= `CH_CTRL_RESET;
               val_reg[g] <= `CH_VAL_RESET;
            end else begin
               if (wr_ok && addr == ch_addr(g, `CH_OFS_CTRL)) begin
                  chc_reg[g] <= {1'b0, wdata[6:0] & {1'b1, (g % 2 == 0), 5'h1F}};
               end
               if (cap_evt[g]) begin
                  val_reg[g] <= cnt_reg;
               end else if (wr_ok && addr == ch_addr(g, `CH_OFS_HI)) begin
                  val_reg[g][15:8] <= wdata;
               end else if (wr_ok && addr == ch_addr(g, `CH_OFS_LO)) begin
                  val_reg[g][7:0] <= wdata;
               end
            end
         end
      end
   endgenerate

   assign {flag_next[`WRAP_IDX], arm_next[`WRAP_IDX]} = flag_upd(flag_reg[`WRAP_IDX], arm_reg[`WRAP_IDX],
      wrap_set, rd_ok & (addr == `ADDR_CTRL), wr_ctrl, wdata[`CTRL_WRAP_FLAG], may_clear);
   assign wrap_irq = flag_reg[`WRAP_IDX] & wrap_ie_reg & ~inhibit_reg;
   assign wake_request = wrap_irq | (|chan_irq);
   assign rdata = rdata_reg;

   wire [7:0] ctrl_rd = {flag_reg[`WRAP_IDX], wrap_ie_reg, halt_reg, 1'b0, 1'b0, div_reg};
   wire [7:0] rd_mux =
      (addr == `ADDR_CTRL) ? ctrl_rd :
      (addr == `ADDR_CNT_HI) ? cnt_reg[15:8] :
      (addr == `ADDR_CNT_LO) ? cnt_reg[7:0] :
      (addr == `ADDR_PER_HI) ? per_reg[15:8] :
      (addr == `ADDR_PER_LO) ? per_reg[7:0] :
      (addr == ch_addr(0, `CH_OFS_CTRL)) ? {flag_reg[0], ch_rd[0][6:0]} :
      (addr == ch_addr(1, `CH_OFS_CTRL)) ? {flag_reg[1], ch_rd[1][6:0]} :
      (addr == ch_addr(2, `CH_OFS_CTRL)) ? {flag_reg[2], ch_rd[2][6:0]} :
      (addr == ch_addr(3, `CH_OFS_CTRL)) ? {flag_reg[3], ch_rd[3][6:0]} :
      (addr == ch_addr(4, `CH_OFS_CTRL)) ? {flag_reg[4], ch_rd[4][6:0]} :
      (addr == ch_addr(5, `CH_OFS_CTRL)) ? {flag_reg[5], ch_rd[5][6:0]} :
      (addr == ch_addr(0, `CH_OFS_HI)) ? val_reg[0][15:8] : (addr == ch_addr(0, `CH_OFS_LO)) ? val_reg[0][7:0] :
      (addr == ch_addr(1, `CH_OFS_HI)) ? val_reg[1][15:8] : (addr == ch_addr(1, `CH_OFS_LO)) ? val_reg[1][7:0] :
      (addr == ch_addr(2, `CH_OFS_HI)) ? val_reg[2][15:8] : (addr == ch_addr(2, `CH_OFS_LO)) ? val_reg[2][7:0] :
      (addr == ch_addr(3, `CH_OFS_HI)) ? val_reg[3][15:8] : (addr == ch_addr(3, `CH_OFS_LO)) ? val_reg[3][7:0] :
      (addr == ch_addr(4, `CH_OFS_HI)) ? val_reg[4][15:8] : (addr == ch_addr(4, `CH_OFS_LO)) ? val_reg[4][7:0] :
      (addr == ch_addr(5, `CH_OFS_HI)) ? val_reg[5][15:8] : (addr == ch_addr(5, `CH_OFS_LO)) ? val_reg[5][7:0] :
      8'h00;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= 6'h00;
         sync2_reg <= 6'h00;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Flags update every cycle, and a new event always beats a pending clear.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= 8'h00;
         flag_reg <= 7'h00;
         arm_reg <= 7'h00;
      end else begin
         rdata_reg <= rd_ok ? rd_mux : 8'h00;
         flag_reg <= flag_next;
         arm_reg <= arm_next;
      end
   end

   // Reset leaves the counter halted until software releases it.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wrap_ie_reg <= 1'b0;
         halt_reg <= 1'b1;
         div_reg <= `DIV_RESET;
      end else if (wr_ctrl) begin
         wrap_ie_reg <= wdata[`CTRL_WRAP_IE];
         halt_reg <= wdata[`CTRL_HALT];
         div_reg <= wdata[`CTRL_DIV_HI:`CTRL_DIV_LO];
      end
   end

   // A clear in the same cycle as a tick wins, so counting restarts from zero.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= `CNT_RESET;
         per_reg <= `PERIOD_RESET;
         inhibit_reg <= 1'b0;
      end else begin
         if (clr_pulse) begin
            cnt_reg <= `CNT_RESET;
         end else if (tick) begin
            cnt_reg <= cnt_next;
         end
         if (wr_ok && addr == `ADDR_PER_HI) begin
            per_reg[15:8] <= wdata;
            inhibit_reg <= 1'b1;
         end else if (wr_ok && addr == `ADDR_PER_LO) begin
            per_reg[7:0] <= wdata;
            inhibit_reg <= 1'b0;
         end
      end
   end

   // Checks on the counter, the flags and the register port.
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   AST_WRAP_SET: assert property (wrap_set && wrap_ie_reg |=> flag_reg[`WRAP_IDX] && wrap_irq)
      else $error("wrap event did not raise request");
   AST_CHAN_FLAG: assert property (ch_evt[0] && chc_reg[0][`CH_IE] |=> chan_irq[0] && wake_request)
      else $error("channel event did not raise request");
   AST_HALT_FREEZE: assert property (halt_reg && !clr_pulse |=> cnt_reg == $past(cnt_reg))
      else $error("counter moved while halted");
   AST_BREAK: assert property (debug_break |-> cap_evt == 6'h00 && !tick)
      else $error("capture or count during break");
   AST_STOP: assert property (stop_mode && !clr_pulse |=> cnt_reg == $past(cnt_reg))
      else $error("counter moved in stop");
   AST_CLEAR: assert property (clr_pulse |=> cnt_reg == `CNT_RESET && rdata[`CTRL_CLEAR] == 1'b0)
      else $error("clear did not zero counter");
   AST_BREAK_PROTECT: assert property (debug_break && !halt_flag_clear_enable && flag_reg[`WRAP_IDX]
      |=> flag_reg[`WRAP_IDX])
      else $error("wrap flag cleared in protected break");
   AST_NO_BLIND_CLEAR: assert property (flag_reg[`WRAP_IDX] && !arm_reg[`WRAP_IDX] |=> flag_reg[`WRAP_IDX])
      else $error("wrap flag cleared without read");
   AST_EXT_INPUT: assert property (div_reg == `DIV_EXT |-> !pin_oe[0])
      else $error("clock pin driven");
   AST_WAIT_BLOCK: assert property (wait_mode && wr |=> $stable(per_reg) && rdata == 8'h00)
      else $error("register access in wait");
   AST_INHIBIT: assert property (inhibit_reg |-> !wrap_set && !wrap_irq)
      else $error("wrap while period upper byte pending");
   AST_SET_WINS: assert property (wrap_set |=> flag_reg[`WRAP_IDX])
      else $error("wrap event lost to a clear");
   AST_CAP_HALT: assert property (halt_reg |-> cap_evt == 6'h00)
      else $error("capture while counter halted");
   AST_RESTART: assert property (tick && !clr_pulse && cnt_reg == per_reg |=> cnt_reg == `CNT_RESET)
      else $error("counter did not restart after period");
   AST_RDATA_IDLE: assert property (!rd_ok |=> rdata == 8'h00)
      else $error("read data outside read cycle");
   AST_WAKE: assert property (wrap_irq |-> wake_request)
      else $error("wrap request did not wake");
   COV_WRAP_CLEAR: cover property (arm_reg[`WRAP_IDX] && wr_ctrl && !wdata[`CTRL_WRAP_FLAG]);
   COV_EXT_TICK: cover property (ext_sel && tick);
   COV_SET_WINS: cover property (wrap_set && arm_reg[`WRAP_IDX] && wr_ctrl);
endmodule

/* verilog/timer_pkg.sv */
// Purpose: Types shared by the timer modules.
// Assumes: Nothing beyond the register header.
// Notes: Holds types only; numbers live in timer_regs.svh.
package timer_pkg;
   typedef logic [15:0] count_t;
   typedef logic [2:0] div_sel_t;
   typedef enum logic [1:0] {mode_idle, mode_capture, mode_compare} chan_mode_e;
endpackage

/* verilog/timer_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing figures of the timer.
// Assumes: 8-bit register data, 6-bit register address.
// Notes: Channel i occupies three registers starting at CH_BASE + 3*i.
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH
`define ADDR_CTRL 6'h00
`define ADDR_CNT_HI 6'h01
`define ADDR_CNT_LO 6'h02
`define ADDR_PER_HI 6'h03
`define ADDR_PER_LO 6'h04
`define ADDR_CH_BASE 6'h05
`define CH_STRIDE 6'h03
`define CH_OFS_CTRL 6'h00
`define CH_OFS_HI 6'h01
`define CH_OFS_LO 6'h02
`define CTRL_WRAP_FLAG 7
`define CTRL_WRAP_IE 6
`define CTRL_HALT 5
`define CTRL_CLEAR 4
`define CTRL_DIV_HI 2
`define CTRL_DIV_LO 0
`define CH_FLAG 7
`define CH_IE 6
`define CH_LINK 5
`define CH_UNLINKED 4
`define CH_ELS_HI 3
`define CH_ELS_LO 2
`define CH_TOV 1
`define CH_MAX 0
`define ELS_OFF 2'b00
`define ELS_TOGGLE 2'b01
`define ELS_CLEAR 2'b10
`define ELS_SET 2'b11
`define DIV_EXT 3'b111
`define PERIOD_RESET 16'hFFFF
`define CH_CTRL_RESET 8'h00
`define CH_VAL_RESET 16'h0000
`define CNT_RESET 16'h0000
`define DIV_RESET 3'b000
`define WRAP_IDX 6
`define CLK_KHZ 125000
`define EXT_CLK_MAX_KHZ 4000
`define EXT_CLK_MIN_CYCLES ((`CLK_KHZ + `EXT_CLK_MAX_KHZ - 1) / `EXT_CLK_MAX_KHZ)
`endif
